// ### core/link_cfg.svh
/*
 * Constants of the serializer control-channel configuration bank: register
 * offsets, field positions, reset values, magic codes and timing counts.
 * Assumes a 125 MHz core clock; included by bare name, definitions only.
 */
// How it works
// - power-up level select from audio clock strap: low 3.3V, high 1.8V
// - level select reads back 0 for 1.8V and 1 for 3.3V
// - writing 0xb5 sets level select, 0xb6 clears it; other values ignored
// - watchdog aborts any control channel transaction not finished in time
// - timeout field bits 7:1 counts 2 ms units; zero should not be programmed
// - watchdog bit 0: 0 enables (default), 1 disables
// - pass-all clear: forward only IDs of remote deserializer or target
// - pass-all set: forward every ID differing from own local ID
// - SDA input delayed against SCL by bits 6:4 times 40 ns
// - SCL and SDA glitches up to bits 3:0 times 5 ns are rejected
// - master SCL high lasts at least 38.0952 ns times (value + 5)
// - master SCL low lasts at least 38.0952 ns times (value + 5)
// - as target, low-time setting is SDA setup before releasing SCL
// - read-only bit 3 mirrors aux audio enable strapped from mode pin 0
// - data path bit 1: 0 is 24-bit plus DE/HS/VS, 1 is 28-bit
// - data path bit 0 enables surround audio; 0 uses 2/4 channel setup
// - surround audio only with data-island transport, never frame transport
// - in a repeater, in-band detected I2S mode may override surround bit
// - self-test counts back channel CRC errors, 8 bits, saturating at 255
// - error counter clears on new self-test start or external clear control
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH

`define OFS_LEVEL_SELECT 8'h15
`define OFS_WATCHDOG 8'h16
`define OFS_FORWARD_CTRL 8'h17
`define OFS_CLOCK_HIGH 8'h18
`define OFS_CLOCK_LOW 8'h19
`define OFS_DATA_PATH 8'h1a
`define OFS_ERROR_COUNT 8'h1b

`define RST_LEVEL_SELECT 8'h01
`define RST_WATCHDOG 8'hfe
`define RST_FORWARD_CTRL 8'h1e
`define RST_CLOCK_HIGH 8'h7f
`define RST_CLOCK_LOW 8'h7f
`define RST_DATA_PATH 8'h04
`define RST_ERROR_COUNT 8'h00

`define CODE_LEVEL_SET 8'hb5
`define CODE_LEVEL_CLEAR 8'hb6

`define WD_DISABLE_BIT 0
`define WD_TIMEOUT_LSB 1
`define FWD_PASS_ALL_BIT 7
`define FWD_HOLD_LSB 4
`define FWD_FILTER_LSB 0
`define DP_SECONDARY_BIT 3
`define DP_RESERVED_BIT 2
`define DP_WIDE_BIT 1
`define DP_SURROUND_BIT 0

`define CLK_PERIOD_PS 8000
`define WD_UNIT_MS 2
`define HOLD_STEP_NS 40
`define FILTER_STEP_NS 5
`define SCL_UNIT_PS 38095
`define SCL_EXTRA_UNITS 5
`define WD_UNIT_CYCLES ((`WD_UNIT_MS * 1000000000) / `CLK_PERIOD_PS)
`define HOLD_STEP_CYCLES ((`HOLD_STEP_NS * 1000) / `CLK_PERIOD_PS)
`define FILTER_STEP_CYCLES \
    (((`FILTER_STEP_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ### core/link_config_bank.sv
/*
 * Configuration and status bank of a video link serializer: I2C level select,
 * control channel watchdog, forwarding filter, I2C input conditioning, master
 * SCL timing, data path mode and self-test back channel error counter.
 * Assumes a local I2C target engine presents decoded register accesses and
 * transaction events synchronous to clk_i; straps are stable at reset release.
 */
`timescale 1ns/1ps
`default_nettype none
`include "link_cfg.svh"

module link_config_bank #(
    parameter int WD_UNIT_CYCLES = `WD_UNIT_CYCLES,
    parameter logic [6:0] LOCAL_ID = 7'h0c,
    parameter int SCL_CNT_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire link_pkg::reg_req_s req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    input wire logic audio_clock_strap_i,
    input wire logic mode_strap_pin_zero_i,
    input wire logic txn_start_i,
    input wire logic txn_done_i,
    output logic txn_abort_o,
    input wire logic [6:0] target_id_i,
    input wire logic target_id_valid_i,
    input wire logic [6:0] remote_deser_id_i,
    input wire logic [6:0] remote_target_id_i,
    output logic forward_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_clean_o,
    output logic sda_clean_o,
    input wire logic master_active_i,
    output logic scl_master_o,
    input wire logic target_stretch_i,
    output logic scl_release_o,
    input wire logic repeater_i,
    input wire logic inband_surround_valid_i,
    input wire logic inband_surround_i,
    input wire logic frame_transport_i,
    input wire logic self_test_start_i,
    input wire logic self_test_active_i,
    input wire logic crc_error_i,
    input wire logic error_clear_i,
    output link_pkg::link_ctrl_s ctrl_o
);

    logic level_reg;
    logic [7:0] watchdog_reg;
    logic [7:0] forward_reg;
    logic [7:0] clock_high_reg;
    logic [7:0] clock_low_reg;
    logic wide_reg;
    logic surround_reg;
    logic secondary_reg;
    logic [7:0] error_reg;
    logic strap_done_reg;
    link_pkg::watchdog_state_e wd_state_reg;
    logic [31:0] wd_tick_reg;
    logic [6:0] wd_units_reg;
    logic [SCL_CNT_W-1:0] scl_cnt_reg;
    logic scl_reg;
    logic [SCL_CNT_W-1:0] setup_cnt_reg;
    logic release_reg;
    logic surround_eff;

    function automatic logic is_write(input link_pkg::reg_req_s r,
                                      input logic [7:0] ofs);
        is_write = r.wr && (r.addr == ofs);
    endfunction

    // oscillator-unit count to core cycles, rounded up for a least time
    function automatic logic [SCL_CNT_W-1:0] scl_cycles(input logic [7:0] v);
        int ps;
        ps = (int'(v) + `SCL_EXTRA_UNITS) * `SCL_UNIT_PS;
        scl_cycles = SCL_CNT_W'((ps + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // straps caught on the first edge after reset release

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_done_reg <= 1'b0;
            secondary_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            secondary_reg <= mode_strap_pin_zero_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_reg <= 1'(`RST_LEVEL_SELECT);
        end else if (!strap_done_reg) begin
            level_reg <= ~audio_clock_strap_i;
        end else if (is_write(req_i, `OFS_LEVEL_SELECT)) begin
            if (req_i.wdata == `CODE_LEVEL_SET) begin
                level_reg <= 1'b1;
            end else if (req_i.wdata == `CODE_LEVEL_CLEAR) begin
                level_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // plain read/write registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_reg <= `RST_WATCHDOG;
            forward_reg <= `RST_FORWARD_CTRL;
            clock_high_reg <= `RST_CLOCK_HIGH;
            clock_low_reg <= `RST_CLOCK_LOW;
        end else begin
            if (is_write(req_i, `OFS_WATCHDOG)) begin
                watchdog_reg <= req_i.wdata;
            end
            if (is_write(req_i, `OFS_FORWARD_CTRL)) begin
                forward_reg <= req_i.wdata;
            end
            if (is_write(req_i, `OFS_CLOCK_HIGH)) begin
                clock_high_reg <= req_i.wdata;
            end
            if (is_write(req_i, `OFS_CLOCK_LOW)) begin
                clock_low_reg <= req_i.wdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_reg <= 1'(`RST_DATA_PATH >> `DP_WIDE_BIT);
            surround_reg <= 1'(`RST_DATA_PATH >> `DP_SURROUND_BIT);
        end else if (is_write(req_i, `OFS_DATA_PATH)) begin
            wide_reg <= req_i.wdata[`DP_WIDE_BIT];
            surround_reg <= req_i.wdata[`DP_SURROUND_BIT];
        end
    end

    // repeater in-band detection overrides, frame transport blocks surround
    always_comb begin
        if (repeater_i && inband_surround_valid_i) begin
            surround_eff = inband_surround_i;
        end else begin
            surround_eff = surround_reg;
        end
        if (frame_transport_i) begin
            surround_eff = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) begin
                case (req_i.addr)
                    `OFS_LEVEL_SELECT: rdata_o <= {7'h00, level_reg};
                    `OFS_WATCHDOG: rdata_o <= watchdog_reg;
                    `OFS_FORWARD_CTRL: rdata_o <= forward_reg;
                    `OFS_CLOCK_HIGH: rdata_o <= clock_high_reg;
                    `OFS_CLOCK_LOW: rdata_o <= clock_low_reg;
                    `OFS_DATA_PATH: begin
                        rdata_o <= {4'h0, secondary_reg, 1'b1,
                                    wide_reg, surround_reg};
                    end
                    `OFS_ERROR_COUNT: rdata_o <= error_reg;
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control channel watchdog

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_state_reg <= link_pkg::WD_IDLE;
            wd_tick_reg <= 32'h0;
            wd_units_reg <= 7'h00;
            txn_abort_o <= 1'b0;
        end else begin
            txn_abort_o <= 1'b0;
            if (txn_start_i) begin
                wd_state_reg <= link_pkg::WD_RUN;
                wd_tick_reg <= 32'h0;
                wd_units_reg <= 7'h00;
            end else begin
                case (wd_state_reg)
                    link_pkg::WD_IDLE: begin
                    end
                    link_pkg::WD_RUN: begin
                        if (txn_done_i || watchdog_reg[`WD_DISABLE_BIT]) begin
                            wd_state_reg <= link_pkg::WD_IDLE;
                        end else if (wd_tick_reg ==
                                     32'(WD_UNIT_CYCLES - 1)) begin
                            wd_tick_reg <= 32'h0;
                            if (wd_units_reg + 7'h01 >=
                                watchdog_reg[7:`WD_TIMEOUT_LSB]) begin
                                wd_state_reg <= link_pkg::WD_EXPIRED;
                                txn_abort_o <= 1'b1;
                            end else begin
                                wd_units_reg <= wd_units_reg + 7'h01;
                            end
                        end else begin
                            wd_tick_reg <= wd_tick_reg + 32'h1;
                        end
                    end
                    link_pkg::WD_EXPIRED: wd_state_reg <= link_pkg::WD_IDLE;
                    default: wd_state_reg <= link_pkg::WD_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // forwarding decision

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            forward_o <= 1'b0;
        end else if (target_id_valid_i) begin
            if (forward_reg[`FWD_PASS_ALL_BIT]) begin
                forward_o <= target_id_i != LOCAL_ID;
            end else begin
                forward_o <= (target_id_i == remote_deser_id_i) ||
                             (target_id_i == remote_target_id_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input conditioning

    pin_filter #(
        .DEPTH_W(4),
        .HOLD_W(3)
    ) scl_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(scl_i),
        .depth_i(forward_reg[3:`FWD_FILTER_LSB]),
        .hold_i(3'h0),
        .pin_o(scl_clean_o)
    );

    pin_filter #(
        .DEPTH_W(4),
        .HOLD_W(3)
    ) sda_filter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(sda_i),
        .depth_i(forward_reg[3:`FWD_FILTER_LSB]),
        .hold_i(forward_reg[6:`FWD_HOLD_LSB]),
        .pin_o(sda_clean_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // master clock generator and target setup timer

    always_ff @(posedge clk_i) begin
        if (rst_i || !master_active_i) begin
            scl_reg <= 1'b1;
            scl_cnt_reg <= '0;
        end else if (scl_reg && scl_cnt_reg + 1'b1 >=
                     scl_cycles(clock_high_reg)) begin
            scl_reg <= 1'b0;
            scl_cnt_reg <= '0;
        end else if (!scl_reg && scl_cnt_reg + 1'b1 >=
                     scl_cycles(clock_low_reg)) begin
            scl_reg <= 1'b1;
            scl_cnt_reg <= '0;
        end else begin
            scl_cnt_reg <= scl_cnt_reg + 1'b1;
        end
    end

    assign scl_master_o = scl_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i || !target_stretch_i) begin
            setup_cnt_reg <= '0;
            release_reg <= 1'b0;
        end else if (setup_cnt_reg + 1'b1 >= scl_cycles(clock_low_reg)) begin
            release_reg <= 1'b1;
        end else begin
            setup_cnt_reg <= setup_cnt_reg + 1'b1;
        end
    end

    assign scl_release_o = release_reg;

    ////////////////////////////////////////////////////////////////////////
    // self-test back channel error counter

    always_ff @(posedge clk_i) begin
        if (rst_i || self_test_start_i || error_clear_i) begin
            error_reg <= `RST_ERROR_COUNT;
        end else if (self_test_active_i && crc_error_i &&
                     error_reg != 8'hff) begin
            error_reg <= error_reg + 8'h01;
        end
    end

    assign ctrl_o = '{
        wide_payload_select: wide_reg,
        surround_enable: surround_eff,
        pass_all: forward_reg[`FWD_PASS_ALL_BIT],
        sda_hold: forward_reg[6:4],
        filter_depth: forward_reg[3:0],
        clock_high: clock_high_reg,
        clock_low: clock_low_reg,
        i2c_level_select: level_reg
    };

endmodule
`default_nettype wire

// ### core/link_pkg.sv
/*
 * Types of the serializer control-channel configuration bank.
 * Assumes link_cfg.svh holds all numbers.
 */
package link_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic wide_payload_select;
        logic surround_enable;
        logic pass_all;
        logic [2:0] sda_hold;
        logic [3:0] filter_depth;
        logic [7:0] clock_high;
        logic [7:0] clock_low;
        logic i2c_level_select;
    } link_ctrl_s;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_RUN,
        WD_EXPIRED
    } watchdog_state_e;

endpackage

// ### core/pin_filter.sv
/*
 * Glitch filter followed by a programmable delay for one I2C input.
 * Assumes the input is already synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "link_cfg.svh"

module pin_filter #(
    parameter int DEPTH_W = 4,
    parameter int HOLD_W = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic [DEPTH_W-1:0] depth_i,
    input wire logic [HOLD_W-1:0] hold_i,
    output logic pin_o
);

    localparam int FCYC = `FILTER_STEP_CYCLES;
    localparam int HCYC = `HOLD_STEP_CYCLES;
    localparam int HMAX = ((1 << HOLD_W) - 1) * HCYC + 1;

    logic [7:0] run_reg;
    logic stable_reg;
    logic [HMAX-1:0] line_reg;
    logic [7:0] limit;

    assign limit = 8'((int'(depth_i) * FCYC) % 256);

    // level must persist beyond the glitch width before it is accepted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 8'h00;
            stable_reg <= 1'b1;
        end else if (pin_i == stable_reg) begin
            run_reg <= 8'h00;
        end else if (run_reg >= limit) begin
            stable_reg <= pin_i;
            run_reg <= 8'h00;
        end else begin
            run_reg <= run_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_reg <= '1;
        end else begin
            line_reg <= {line_reg[HMAX-2:0], stable_reg};
        end
    end

    // tap chosen by hold setting delays the filtered level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 1'b1;
        end else begin
            pin_o <= line_reg[int'(hold_i) * HCYC];
        end
    end

endmodule
`default_nettype wire

// ### tb/host_model.sv
/* local host issuing decoded register accesses.
   assumes one request per task call, driven just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_i,
    output link_pkg::reg_req_s req_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    initial req_o = '0;
    // whole byte written, bus scrambled once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) #1;
        req_o = '{a, d, 1'b1, 1'b0};
        @(posedge clk_i) #1;
        req_o = '{~a, ~d, 1'b0, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i) #1;
        req_o = '{a, 8'h5a, 1'b0, 1'b1};
        @(posedge clk_i) #1;
        req_o = '{~a, 8'ha5, 1'b0, 1'b0};
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
    endtask
endmodule
`default_nettype wire

// ### tb/link_config_bank_props.sv
/* assertions on the ports of link_config_bank.
   assumes the bind at the foot and the instance's own parameters. */
`timescale 1ns/1ps
`default_nettype none
module link_config_bank_props #(
    parameter int WD_UNIT_CYCLES = 10,
    parameter logic [6:0] LOCAL_ID = 7'h0c
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire link_pkg::reg_req_s req_i,
    input wire logic rvalid_o,
    input wire logic audio_clock_strap_i,
    input wire logic txn_start_i,
    input wire logic txn_done_i,
    input wire logic txn_abort_o,
    input wire logic [6:0] target_id_i,
    input wire logic target_id_valid_i,
    input wire logic [6:0] remote_deser_id_i,
    input wire logic [6:0] remote_target_id_i,
    input wire logic forward_o,
    input wire logic master_active_i,
    input wire logic scl_master_o,
    input wire logic target_stretch_i,
    input wire logic scl_release_o,
    input wire logic frame_transport_i,
    input wire link_pkg::link_ctrl_s ctrl_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    int run_cnt, hi_cnt, lo_cnt, st_cnt, min_hi, min_lo;
    logic in_txn;
    // age of the open transaction
    always_ff @(posedge clk_i) begin
        run_cnt <= txn_start_i ? 0 : run_cnt + 1;
        in_txn <= !rst_i && (txn_start_i ||
            (in_txn && !txn_done_i && !txn_abort_o));
    end
    // scl phase and stretch lengths
    always_ff @(posedge clk_i) begin
        hi_cnt <= scl_master_o ? hi_cnt + 1 : 0;
        lo_cnt <= scl_master_o ? 0 : lo_cnt + 1;
        st_cnt <= target_stretch_i ? st_cnt + 1 : 0;
    end
    always_comb begin
        min_hi = ((int'(ctrl_o.clock_high) + 5) * 38095 + 7999) / 8000;
        min_lo = ((int'(ctrl_o.clock_low) + 5) * 38095 + 7999) / 8000;
    end
    ////////////////////////////////////////
    a_read_answer: assert property (req_i.rd |=> rvalid_o)
        else $error("read not answered");
    a_strap_load: assert property ($fell(rst_i) |=>
        ctrl_o.i2c_level_select == !$past(audio_clock_strap_i))
        else $error("level strap not loaded");
    a_level_set: assert property (req_i.wr && req_i.addr == 8'h15 &&
        req_i.wdata == 8'hb5 |=> ctrl_o.i2c_level_select)
        else $error("level set code ignored");
    a_abort_late: assert property (txn_abort_o |->
        in_txn && run_cnt >= WD_UNIT_CYCLES - 2)
        else $error("abort too early");
    a_abort_pulse: assert property (txn_abort_o |=> !txn_abort_o)
        else $error("abort too long");
    a_fwd_filter: assert property (target_id_valid_i &&
        !ctrl_o.pass_all && target_id_i != remote_deser_id_i &&
        target_id_i != remote_target_id_i |=> !forward_o)
        else $error("unmatched id forwarded");
    a_fwd_all: assert property (target_id_valid_i &&
        ctrl_o.pass_all && target_id_i != LOCAL_ID |=> forward_o)
        else $error("pass all dropped");
    a_scl_high: assert property ($fell(scl_master_o) &&
        master_active_i |-> hi_cnt >= min_hi)
        else $error("scl high too short");
    a_scl_low: assert property ($rose(scl_master_o) &&
        master_active_i |-> lo_cnt >= min_lo)
        else $error("scl low too short");
    a_setup_wait: assert property ($rose(scl_release_o) |->
        st_cnt >= min_lo - 1)
        else $error("early release");
    a_frame_surround: assert property (frame_transport_i |->
        !ctrl_o.surround_enable)
        else $error("surround with frame transport");
    c_abort: cover property (txn_abort_o);
    c_forward: cover property ($rose(forward_o));
    c_release: cover property ($rose(scl_release_o));
endmodule
bind link_config_bank link_config_bank_props #(
    .WD_UNIT_CYCLES(WD_UNIT_CYCLES),
    .LOCAL_ID(LOCAL_ID)
) props_i (
    .clk_i, .rst_i, .req_i, .rvalid_o, .audio_clock_strap_i,
    .txn_start_i, .txn_done_i, .txn_abort_o, .target_id_i,
    .target_id_valid_i, .remote_deser_id_i, .remote_target_id_i,
    .forward_o, .master_active_i, .scl_master_o, .target_stretch_i,
    .scl_release_o, .frame_transport_i, .ctrl_o
);
`default_nettype wire

// ### tb/testbench.sv
/* self-checking bench for link_config_bank.
   assumes host_model drives requests; short watchdog unit. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int WDU = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    link_pkg::reg_req_s req_i;
    link_pkg::link_ctrl_s ctrl_o;
    logic [7:0] rdata_o;
    logic [6:0] target_id_i = 7'h00;
    logic [6:0] remote_deser_id_i = 7'h30;
    logic [6:0] remote_target_id_i = 7'h31;
    logic audio_clock_strap_i = 1'b0, mode_strap_pin_zero_i = 1'b1;
    logic txn_start_i = 1'b0, txn_done_i = 1'b0, target_id_valid_i = 1'b0;
    logic scl_i = 1'b1, sda_i = 1'b1, master_active_i = 1'b0;
    logic target_stretch_i = 1'b0, repeater_i = 1'b0;
    logic inband_surround_valid_i = 1'b0, inband_surround_i = 1'b0;
    logic frame_transport_i = 1'b0, self_test_start_i = 1'b0;
    logic self_test_active_i = 1'b0, crc_error_i = 1'b0, error_clear_i = 1'b0;
    logic rvalid_o, txn_abort_o, forward_o, scl_clean_o, sda_clean_o;
    logic scl_master_o, scl_release_o;
    int miscompares = 0, check_count = 0;
    link_config_bank #(.WD_UNIT_CYCLES(WDU)) link_config_bank_i (
        .clk_i, .rst_i, .req_i, .rdata_o, .rvalid_o, .audio_clock_strap_i,
        .mode_strap_pin_zero_i, .txn_start_i, .txn_done_i, .txn_abort_o,
        .target_id_i, .target_id_valid_i, .remote_deser_id_i,
        .remote_target_id_i, .forward_o, .scl_i, .sda_i, .scl_clean_o,
        .sda_clean_o, .master_active_i, .scl_master_o, .target_stretch_i,
        .scl_release_o, .repeater_i, .inband_surround_valid_i,
        .inband_surround_i, .frame_transport_i, .self_test_start_i,
        .self_test_active_i, .crc_error_i, .error_clear_i, .ctrl_o
    );
    host_model host_model_i (
        .clk_i, .req_o(req_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o)
    );
    initial forever #4 clk_i = ~clk_i;
    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    // must: running out of the bound is a hang
    task automatic wait_for(ref logic s, input logic v, input int lim,
                            output int n, input logic must);
        n = 0;
        while (s !== v && n < lim) begin
            tick(1);
            n++;
        end
        if (must && n == lim) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_i.wr(a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_model_i.rd(a, d);
        check(d, e);
    endtask
    task automatic fwd(input logic [6:0] id, input logic e);
        target_id_i = id;
        pulse(target_id_valid_i);
        check(forward_o, e);
    endtask
    ////////////////////////////////////////
    task automatic reset_values();
        logic [7:0] e[8] = '{8'h01, 8'hfe, 8'h1e, 8'h7f, 8'h7f, 8'h0c,
                              8'h00, 8'h00};
        for (int i = 0; i < 8; i++) begin
            rdc((i < 7) ? 8'h15 + 8'(i) : 8'h20, e[i]);
        end
    endtask
    task automatic level_codes();
        wr(8'h15, 8'h12);
        rdc(8'h15, 8'h01);
        wr(8'h15, 8'hb6);
        rdc(8'h15, 8'h00);
        wr(8'h15, 8'hb5);
        rdc(8'h15, 8'h01);
        audio_clock_strap_i = 1'b1;
        rst_i = 1'b1;
        tick(2);
        rst_i = 1'b0;
        rdc(8'h15, 8'h00);
    endtask
    task automatic watchdog();
        int n;
        wr(8'h16, 8'h04);
        pulse(txn_start_i);
        wait_for(txn_abort_o, 1'b1, 100, n, 1'b1);
        check(n >= 2 * WDU - 1 && n <= 2 * WDU + 2, 1'b1);
        pulse(txn_start_i);
        tick(12);
        pulse(txn_start_i);
        wait_for(txn_abort_o, 1'b1, 100, n, 1'b1);
        check(n >= 2 * WDU - 1 && n <= 2 * WDU + 2, 1'b1);
        pulse(txn_start_i);
        pulse(txn_done_i);
        wait_for(txn_abort_o, 1'b1, 3 * WDU, n, 1'b0);
        check(n == 3 * WDU, 1'b1);
        wr(8'h16, 8'h05);
        pulse(txn_start_i);
        wait_for(txn_abort_o, 1'b1, 3 * WDU, n, 1'b0);
        check(n == 3 * WDU, 1'b1);
        wr(8'h16, 8'hfe);
    endtask
    task automatic forwarding();
        remote_deser_id_i = 7'h33;
        remote_target_id_i = 7'h41;
        fwd(7'h33, 1'b1);
        fwd(7'h41, 1'b1);
        fwd(7'h22, 1'b0);
        wr(8'h17, 8'h9e);
        fwd(7'h22, 1'b1);
        fwd(7'h0c, 1'b0);
        wr(8'h17, 8'h1e);
    endtask
    task automatic data_path();
        wr(8'h1a, 8'hff);
        rdc(8'h1a, 8'h0f);
        frame_transport_i = 1'b1;
        tick(1);
        check(ctrl_o.surround_enable, 1'b0);
        frame_transport_i = 1'b0;
        tick(1);
        check(ctrl_o.surround_enable, 1'b1);
        repeater_i = 1'b1;
        inband_surround_valid_i = 1'b1;
        tick(1);
        check(ctrl_o.surround_enable, 1'b0);
        wr(8'h1a, 8'h01);
        check(ctrl_o.wide_payload_select, 1'b0);
    endtask
    task automatic error_count();
        self_test_active_i = 1'b1;
        pulse(self_test_start_i);
        crc_error_i = 1'b1;
        tick(260);
        crc_error_i = 1'b0;
        rdc(8'h1b, 8'hff);
        pulse(error_clear_i);
        rdc(8'h1b, 8'h00);
        crc_error_i = 1'b1;
        tick(3);
        crc_error_i = 1'b0;
        wr(8'h1b, 8'h55);
        rdc(8'h1b, 8'h03);
        pulse(self_test_start_i);
        rdc(8'h1b, 8'h00);
        self_test_active_i = 1'b0;
    endtask
    task automatic pin_timing();
        int n;
        scl_i = 1'b0;
        tick(5);
        scl_i = 1'b1;
        wait_for(scl_clean_o, 1'b0, 40, n, 1'b0);
        check(n == 40, 1'b1);
        sda_i = 1'b0;
        wait_for(sda_clean_o, 1'b0, 60, n, 1'b1);
        check(n >= 14 && n <= 30, 1'b1);
        sda_i = 1'b1;
        wr(8'h18, 8'h00);
        wr(8'h19, 8'h00);
        master_active_i = 1'b1;
        wait_for(scl_master_o, 1'b0, 200, n, 1'b1);
        wait_for(scl_master_o, 1'b1, 200, n, 1'b1);
        check(n + 1 >= 24, 1'b1);
        wait_for(scl_master_o, 1'b0, 200, n, 1'b1);
        check(n + 1 >= 24, 1'b1);
        master_active_i = 1'b0;
        target_stretch_i = 1'b1;
        wait_for(scl_release_o, 1'b1, 100, n, 1'b1);
        check(n >= 24 && n <= 28, 1'b1);
        target_stretch_i = 1'b0;
    endtask
    initial begin
        tick(6);
        rst_i = 1'b0;
        reset_values();
        level_codes();
        watchdog();
        forwarding();
        data_path();
        error_count();
        pin_timing();
        report_and_stop();
    end
    initial begin
        #80000;
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
